// *** inc/xoc_pkg.sv ***
// constants for the crystal oscillator control block
// assumes an apb slave with 32-bit data and one aligned word per register
`default_nettype none

package xoc_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [4:0]  XOC_CTRL_OFF    = 5'h00;
	localparam logic [4:0]  XOC_STATUS_OFF  = 5'h04;
	localparam logic [4:0]  XOC_PAUSE_OFF   = 5'h08;
	localparam logic [4:0]  XOC_STARTUP_OFF = 5'h0c;
	localparam logic [4:0]  XOC_COUNT_OFF   = 5'h1c;

	// ****************************************
	// field positions
	// ****************************************
	localparam int XOC_ONOFF_LSB  = 12;  // on/off code 23:12
	localparam int XOC_STABLE_BIT = 31;  // status stable flag
	localparam int XOC_ILLEGAL_BIT = 24; // status illegal write flag
	localparam int XOC_ENABLED_BIT = 12; // status enabled flag
	localparam int XOC_QUAD_BIT   = 20;  // startup delay_quadruple
	localparam int XOC_GROUP_LOG2 = 8;   // 256 crystal periods per unit

	// ****************************************
	// codes and reset values
	// ****************************************
	localparam logic [11:0] XOC_CODE_OFF    = 12'hd1e;
	localparam logic [11:0] XOC_CODE_ON     = 12'hfab;
	localparam logic [11:0] XOC_BAND_ONE_TO_FIFTEEN = 12'haa0;
	localparam logic [31:0] XOC_PAUSE_CODE  = 32'h636f_6d61;
	localparam logic [31:0] XOC_WAKE_CODE   = 32'h7761_6b65;
	localparam logic [13:0] XOC_DELAY_RST   = 14'h00c4;
	localparam logic [7:0]  XOC_COUNT_RST   = 8'h00;

	// ****************************************
	// start-up sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		XOC_ST_OFF    = 3'b001, // oscillator off or paused
		XOC_ST_WAIT   = 3'b010, // counting start-up groups
		XOC_ST_STABLE = 3'b100  // delay done, clock usable
	} xoc_state_t;

endpackage

`default_nettype wire

// *** logic/xoc_top.sv ***
// crystal oscillator control: registers, start-up timer, down counter
// assumes the crystal clock arrives as a pin, far slower than ref_clk
//
// Function
// - on/off code in 23:12, d1e off, fab on
// - any other on/off code means on
// - on/off field resets to off
// - band field reads aa0, writes ignored
// - stable bit 31 only when running and timed
// - illegal writes set bit 24, write clears
// - bit 12 shows oscillator switched on
// - status band copy 1:0 reads zero
// - pause code stops, wake code runs
// - pause resets to wake, bad writes wake
// - delay 13:0 resets c4, units of 256
// - bit 20 multiplies delay by four
// - 8-bit counter decrements on crystal, stops zero
// - stable when group count reaches delay
// - non-zero count write loads and starts
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module xoc_top
	import xoc_pkg::*;
(
	input  wire logic        ref_clk,     // bus and control clock
	input  wire logic        rst_n,       // synchronous reset
	input  wire logic        xtal_clk_in, // crystal clock from core
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb direction
	input  wire logic [11:0] paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error, unmapped
	output logic             osc_run_en   // enable to analog core
);

	// ****************************************
	// declarations
	// ****************************************
	logic [11:0] onoff_reg;      // stored on/off code
	logic [31:0] pause_reg;      // stored pause code
	logic [13:0] delay_reg;      // start-up delay units
	logic        quad_reg;       // delay_quadruple
	logic [7:0]  count_reg;      // crystal down counter
	logic        illegal_reg;    // illegal_write_flag
	logic        osc_on;         // on/off code says on
	logic        running;        // on and not paused
	logic        xtal_s1_reg;    // synchroniser first stage
	logic        xtal_s2_reg;    // synchroniser second stage
	logic        xtal_s3_reg;    // edge detect history
	logic        xtal_edge;      // one pulse per crystal period
	logic [7:0]  sub_cnt_reg;    // periods inside one group
	logic [15:0] grp_cnt_reg;    // completed groups
	logic [15:0] target;         // groups needed for stable
	xoc_state_t  state_reg;      // start-up sequencer
	xoc_state_t  state_next;     // its next value
	logic        access;         // access phase in progress
	logic        commit;         // the edge a transfer completes
	logic        wr_commit;      // write taking effect
	logic        mapped;         // address hits a register
	logic [4:0]  word_addr;      // low address bits
	logic [31:0] rd_data;        // read mux output
	logic        bad_ctrl;       // illegal control write
	logic        bad_pause;      // illegal pause write
	logic        clr_illegal;    // software clear of flag

	// ****************************************
	// apb handshake
	// ****************************************

	// one wait state: pready rises in the second access cycle
	assign access    = psel & penable;
	assign commit    = access & pready;
	assign wr_commit = commit & pwrite & mapped;
	assign word_addr = paddr[4:0];

	// decode, upper address bits must be zero
	always_comb begin
		mapped = 1'b0;
		if (paddr[11:5] == 7'h00) begin
			case (word_addr)
				XOC_CTRL_OFF,
				XOC_STATUS_OFF,
				XOC_PAUSE_OFF,
				XOC_STARTUP_OFF,
				XOC_COUNT_OFF: mapped = 1'b1;
				default:       mapped = 1'b0;
			endcase
		end
	end

	// ready pulses for one cycle per transfer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~mapped; // unmapped gives an error
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// read data registered with pready, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (access && !pready && !pwrite) begin
			prdata <= mapped ? rd_data : 32'h0000_0000; // unmapped reads zero, upper bits too
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// read multiplexer
	// ****************************************

	// reserved bits read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		case (word_addr)
			XOC_CTRL_OFF: begin
				rd_data[23:12] = onoff_reg;
				rd_data[11:0]  = XOC_BAND_ONE_TO_FIFTEEN;
			end
			XOC_STATUS_OFF: begin
				rd_data[XOC_STABLE_BIT]  = (state_reg == XOC_ST_STABLE);
				rd_data[XOC_ILLEGAL_BIT] = illegal_reg;
				rd_data[XOC_ENABLED_BIT] = osc_on;
				rd_data[1:0]             = 2'b00;
			end
			XOC_PAUSE_OFF: begin
				rd_data = pause_reg;
			end
			XOC_STARTUP_OFF: begin
				rd_data[13:0]         = delay_reg;
				rd_data[XOC_QUAD_BIT] = quad_reg;
			end
			XOC_COUNT_OFF: begin
				// counter lives on ref_clk, so no crossing needed
				rd_data[7:0] = count_reg;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************
	// control register
	// ****************************************

	// everything except the off code turns the oscillator on
	assign osc_on  = (onoff_reg != XOC_CODE_OFF);
	assign running = osc_on & (pause_reg != XOC_PAUSE_CODE);

	// bad code or any band other than the one legal value
	assign bad_ctrl = wr_commit && (word_addr == XOC_CTRL_OFF) &&
		(((pwdata[23:12] != XOC_CODE_OFF) && (pwdata[23:12] != XOC_CODE_ON)) ||
		(pwdata[11:0] != XOC_BAND_ONE_TO_FIFTEEN));

	// the code is kept as written so software reads it back
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			onoff_reg <= XOC_CODE_OFF;
		end else if (wr_commit && word_addr == XOC_CTRL_OFF) begin
			onoff_reg <= pwdata[23:12];
		end
	end

	// ****************************************
	// pause register
	// ****************************************

	assign bad_pause = wr_commit && (word_addr == XOC_PAUSE_OFF) &&
		(pwdata != XOC_PAUSE_CODE) && (pwdata != XOC_WAKE_CODE);

	// an unknown code falls back to wake, never to pause
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pause_reg <= XOC_WAKE_CODE;
		end else if (wr_commit && word_addr == XOC_PAUSE_OFF) begin
			if (pwdata == XOC_PAUSE_CODE) begin
				pause_reg <= XOC_PAUSE_CODE;
			end else begin
				pause_reg <= XOC_WAKE_CODE;
			end
		end
	end

	// ****************************************
	// illegal write flag
	// ****************************************

	// writing one to bit 24 of status clears it
	assign clr_illegal = wr_commit && (word_addr == XOC_STATUS_OFF) &&
		pwdata[XOC_ILLEGAL_BIT];

	// a new illegal write wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			illegal_reg <= 1'b0;
		end else if (bad_ctrl || bad_pause) begin
			illegal_reg <= 1'b1;
		end else if (clr_illegal) begin
			illegal_reg <= 1'b0;
		end
	end

	// ****************************************
	// start-up delay register
	// ****************************************

	// changes while waiting take effect on the running compare
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			delay_reg <= XOC_DELAY_RST;
			quad_reg  <= 1'b0;
		end else if (wr_commit && word_addr == XOC_STARTUP_OFF) begin
			delay_reg <= pwdata[13:0];
			quad_reg  <= pwdata[XOC_QUAD_BIT];
		end
	end

	// groups needed, four times more with the quadruple bit
	assign target = quad_reg ? {delay_reg, 2'b00} : {2'b00, delay_reg};

	// ****************************************
	// crystal clock sampling
	// ****************************************

	// two flops before use, a third only for edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			xtal_s1_reg <= 1'b0;
			xtal_s2_reg <= 1'b0;
			xtal_s3_reg <= 1'b0;
		end else begin
			xtal_s1_reg <= xtal_clk_in;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_s3_reg <= xtal_s2_reg;
		end
	end

	// rising edge; crystal must stay well below half of ref_clk
	assign xtal_edge = xtal_s2_reg & ~xtal_s3_reg;

	// ****************************************
	// start-up timer
	// ****************************************

	// counts crystal periods in groups of 256 while in the wait state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sub_cnt_reg <= 8'h00;
			grp_cnt_reg <= 16'h0000;
		end else if (state_reg != XOC_ST_WAIT) begin
			sub_cnt_reg <= 8'h00;
			grp_cnt_reg <= 16'h0000;
		end else if (xtal_edge) begin
			sub_cnt_reg <= sub_cnt_reg + 8'h01;
			if (sub_cnt_reg == 8'hff) begin
				grp_cnt_reg <= grp_cnt_reg + 16'h0001;
			end
		end
	end

	// sequencer: off, waiting, stable
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			XOC_ST_OFF: begin
				if (running) begin
					state_next = XOC_ST_WAIT;
				end
			end
			XOC_ST_WAIT: begin
				if (!running) begin
					state_next = XOC_ST_OFF;
				end else if (grp_cnt_reg >= target) begin
					state_next = XOC_ST_STABLE;
				end
			end
			XOC_ST_STABLE: begin
				// leaving run drops stable at once
				if (!running) begin
					state_next = XOC_ST_OFF;
				end
			end
			default: begin
				state_next = XOC_ST_OFF;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= XOC_ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// crystal down counter
	// ****************************************

	// a write loads at once; otherwise step down on each period until zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_reg <= XOC_COUNT_RST;
		end else if (wr_commit && word_addr == XOC_COUNT_OFF) begin
			count_reg <= pwdata[7:0];
		end else if (xtal_edge && count_reg != 8'h00) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	// ****************************************
	// analog core enable
	// ****************************************

	// registered so the core sees a clean level
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			osc_run_en <= 1'b0;
		end else begin
			osc_run_en <= running;
		end
	end

endmodule // xoc_top

`default_nettype wire

// *** verification/xoc_top_props.sv ***
// checker: port-level timing and register behaviour of xoc_top
// assumes a single ref_clk domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module xoc_props
	import xoc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        osc_run_en
);
	// ****************************************
	// helper state, tracked from committed writes
	// ****************************************
	logic on_q;     // last on/off code was not the off code
	logic paused_q; // last pause write was the pause code
	wire logic cmt = psel & penable & pready & pwrite & ~pslverr; // write commit
	wire logic rd_ok = pready & psel & ~pwrite & ~pslverr;        // read answer
	wire logic run_exp = on_q & ~paused_q;                        // expected run
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			on_q     <= 1'b0;
			paused_q <= 1'b0;
		end else if (cmt) begin
			if (paddr == {7'h00, XOC_CTRL_OFF})
				on_q <= pwdata[23:12] != XOC_CODE_OFF;
			if (paddr == {7'h00, XOC_PAUSE_OFF})
				paused_q <= pwdata == XOC_PAUSE_CODE;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable; endsequence

	run_track_a: assert property (osc_run_en == $past(run_exp))
		else $error("run enable does not follow control and pause");
	rst_quiet_a: assert property ($rose(rst_n) |-> !osc_run_en && !pready)
		else $error("outputs active right after reset");
	band_read_a: assert property (rd_ok && paddr == 12'h000 |-> prdata[11:0] == 12'haa0)
		else $error("band field not fixed");
	status_band_a: assert property (rd_ok && paddr == 12'h004 |-> prdata[1:0] == 2'b00)
		else $error("status band copy not zero");
	en_bit_a: assert property (rd_ok && paddr == 12'h004 |-> prdata[12] == on_q)
		else $error("enabled bit wrong");
	stable_run_a: assert property (rd_ok && paddr == 12'h004 && !$past(osc_run_en) |-> !prdata[31])
		else $error("stable while not running");
	ready_time_a: assert property (setup_s ##1 access_s |=> pready)
		else $error("pready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error without ready or with data");
endmodule // xoc_props

bind xoc_top xoc_props chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .osc_run_en(osc_run_en));

`default_nettype wire

// *** verification/xoc_xtal_model.sv ***
// model of the analog crystal core: clock only while enabled
// assumes the run enable is a clean level from the control block
`timescale 1ns/1ps
`default_nettype none

module xoc_xtal_model #(
	parameter int HALF_NS = 20 // 25 mhz crystal, well below the edge-detect limit
) (
	input  wire logic osc_run_en,
	output var  logic xtal_clk_in
);
	// clock stands low while the core is off or paused
	initial xtal_clk_in = 1'b0;
	always begin
		wait (osc_run_en);
		#(HALF_NS) xtal_clk_in = 1'b1;
		#(HALF_NS) xtal_clk_in = 1'b0;
	end
endmodule // xoc_xtal_model

`default_nettype wire

// *** verification/xoc_top_tb_top.sv ***
// self-checking bench for xoc_top over apb with a crystal model
// assumes 200 mhz ref_clk and a 25 mhz crystal
`timescale 1ns/1ps
`default_nettype none

module crystal_osc_control_tb_top;
	import xoc_pkg::*;
	localparam int XP = 40; // crystal period in ns
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, osc_run_en, xtal_clk_in, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int failures = 0;
	int checks = 0;

	xoc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .xtal_clk_in(xtal_clk_in), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_run_en(osc_run_en));
	xoc_xtal_model #(.HALF_NS(XP / 2)) xtal_u (.osc_run_en(osc_run_en), .xtal_clk_in(xtal_clk_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ****************************************
	// bus and compare tasks
	// ****************************************
	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no assumed wait count: only the watchdog ends a hung transfer
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset();
		apb(0, 12'h000, 0); chk(r, 32'h00d1_eaa0);
		apb(0, 12'h004, 0); chk(r, 32'h0000_0000);
		apb(0, 12'h008, 0); chk(r, 32'h7761_6b65);
		apb(0, 12'h00c, 0); chk(r, 32'h0000_00c4);
		apb(0, 12'h01c, 0); chk(r, 32'h0000_0000);
		$display("reset test done");
	endtask
	// start with delay 1, optionally quadrupled; time until stable
	task t_start(input logic q);
		realtime t0, lo;
		int n;
		n = 0;
		lo = 256.0 * (q ? 4 : 1) * XP;
		apb(1, 12'h00c, {11'h000, q, 20'h0_0001});
		apb(0, 12'h00c, 0); chk(r, {11'h000, q, 20'h0_0001});
		apb(1, 12'h000, 32'h00fa_baa0);
		t0 = $realtime;
		apb(0, 12'h004, 0); chk(r & 32'h8000_1000, 32'h0000_1000);
		while (r[31] !== 1'b1 && ++n < 20000) apb(0, 12'h004, 0);
		chk({31'h0, ($realtime - t0) >= lo && ($realtime - t0) <= lo + 300}, 1);
		// bench logic runs on ref_clk, never on the crystal, so off is safe
		apb(1, 12'h000, 32'h00d1_eaa0);
		apb(0, 12'h004, 0); chk(r & 32'h8000_1000, 0);
		$display("start test done");
	endtask
	task t_illegal();
		apb(1, 12'h000, 32'h0012_3aa1);
		apb(0, 12'h000, 0); chk(r[11:0], 12'haa0);
		apb(0, 12'h004, 0); chk(r & 32'h0100_1003, 32'h0100_1000);
		chk(osc_run_en, 1);
		apb(1, 12'h004, 32'h0100_0000);
		apb(0, 12'h004, 0); chk(r[24], 0);
		$display("illegal test done");
	endtask
	task t_pause();
		// no plls hang off this crystal here and the bench itself wakes it
		apb(1, 12'h008, XOC_PAUSE_CODE);
		apb(0, 12'h008, 0); chk(r, 32'h636f_6d61);
		chk(osc_run_en, 0);
		apb(1, 12'h008, 32'h1234_5678);
		apb(0, 12'h008, 0); chk(r, 32'h7761_6b65);
		chk(osc_run_en, 1);
		apb(0, 12'h004, 0); chk(r[24], 1);
		$display("pause test done");
	endtask
	task t_count();
		apb(1, 12'h01c, 32'h0000_0020);
		// load seen at once, at most one crystal edge has passed yet
		apb(0, 12'h01c, 0); chk({31'h0, r >= 32'h1f && r <= 32'h20}, 1);
		repeat (8 * XP / 5) @(posedge ref_clk);
		// about nine crystal periods after the load
		apb(0, 12'h01c, 0); chk({31'h0, r >= 32'h17 && r <= 32'h19}, 1);
		repeat (40 * XP / 5) @(posedge ref_clk);
		apb(0, 12'h01c, 0); chk(r, 0);
		apb(0, 12'h010, 0); chk({31'h0, e}, 1);
		chk(r, 0);
		// upper address bits alias a real register unless decoded
		apb(0, 12'h100, 0); chk({31'h0, e}, 1);
		chk(r, 0);
		$display("count test done");
	endtask

	task close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_start(1'b0);
		t_start(1'b1);
		t_illegal();
		t_pause();
		t_count();
		close_out();
	end
	initial begin
		#400us;
		failures++;
		close_out();
	end
endmodule // crystal_osc_control_tb_top

`default_nettype wire
